// [bapf_framer.sv]
// bapf_framer.sv : beacon advertising payload framer, byte stream toward the radio
//
// Functional notes
// (R1) every payload opens 0x02, 0x01, 0x06
// (R2) flags set discoverable and no classic bits
// (R3) uid/tlm carry uuid list and service data
// (R4) uid frame: length 0x17, type 0x00, power
// (R5) uid namespace bytes 13-22, instance 23-28
// (R6) uid bytes 29 and 30 sent zero
// (R7) uid power byte is 8-bit zero-metre value
// (R8) tlm frame: length 0x10, type 0x20, version 0x00
// (R9) tlm battery millivolts at bytes 13, 14
// (R10) tlm temperature at bytes 15, 16
// (R11) tlm pdu count follows temperature, reboot clears
// (R12) tlm ends with uptime, reboot clears
// (R13) tlm multi-byte fields most significant first
// (R14) custom: length at most 0x1B, type 0xFF
// (R15) custom company id at bytes 5, 6
// (R16) custom data bytes 7-30, at most 24
// (R17) proprietary: 128-bit id, two 16-bit, power
// (R18) bytes ascend, one per handshake, last flagged
// (R19) source holds fields stable through payload
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "bapf_map.svh"
module bapf_framer
  import bapf_pkg::*;
#(
  parameter logic [15:0] SVC_UUID = 16'h5A3C, // arbitrary value, set per product
  parameter int TICK_CYCLES = `BAPF_UPTIME_TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // proprietary id fields
  input wire logic [127:0] prop_id,
  input wire logic [15:0] prop_val_a,
  input wire logic [15:0] prop_val_b,
  input wire logic [7:0] prop_tx_power,
  // unique-id fields
  input wire logic [7:0] uid_tx_power,
  input wire logic [79:0] uid_namespace,
  input wire logic [47:0] uid_instance,
  // telemetry fields
  input wire logic [15:0] battery_millivolts,
  input wire logic [15:0] tlm_temperature,
  // custom fields
  input wire logic [7:0] cust_len,
  input wire logic [15:0] cust_company,
  input wire logic [191:0] cust_data,
  // byte stream to the radio
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last
);

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("bapf_framer: TICK_CYCLES must be at least 1");
  end

  bapf_state_t state_ff; // sequencer state
  bapf_state_t nxt_state; // next sequencer state
  bapf_fmt_t fmt_cfg_ff; // layout chosen by software
  bapf_fmt_t fmt_ff; // layout of the payload in flight
  logic [4:0] idx_ff; // index of the byte on tx_data
  logic [7:0] data_ff; // byte presented to the radio
  logic [4:0] last_ff; // last index of the payload in flight
  logic [31:0] adv_snap_ff; // pdu tally frozen at payload start
  logic [31:0] upt_snap_ff; // uptime frozen at payload start
  logic [31:0] adv_pdu_count; // live pdu tally
  logic [31:0] uptime_count; // live uptime
  logic [31:0] rdata_ff; // registered read answer
  logic start_req; // software start strobe
  logic reboot_req; // software reboot strobe
  logic launch; // payload begins this cycle
  logic take; // radio accepts a byte this cycle
  logic done; // final byte accepted
  logic [7:0] cust_len_cl; // custom length clamped to its legal range

  // reboot and start are write-one pulses in the control word
  assign start_req = reg_wr && (reg_addr == `BAPF_REG_CTRL) && reg_wdata[`BAPF_CTRL_START];
  assign reboot_req = reg_wr && (reg_addr == `BAPF_REG_CTRL) && reg_wdata[`BAPF_CTRL_REBOOT];
  // a start while busy is dropped; the radio owns the payload until its end
  assign launch = start_req && (state_ff == BAPF_ST_IDLE);
  assign take = tx_valid && tx_ready;
  assign done = take && tx_last;

  // (R14) never announce more than 27 bytes, never fewer than type and company
  always_comb begin
    if (cust_len > `BAPF_MFR_LEN_MAX) begin
      cust_len_cl = `BAPF_MFR_LEN_MAX;
    end else if (cust_len < `BAPF_MFR_LEN_MIN) begin
      cust_len_cl = `BAPF_MFR_LEN_MIN;
    end else begin
      cust_len_cl = cust_len;
    end
  end

  // last index of a layout; used only at launch to load last_ff
  function automatic logic [4:0] last_index(input bapf_fmt_t f, input logic [7:0] clen);
    unique case (f)
      BAPF_FMT_PROP: last_index = `BAPF_PROP_LAST;
      BAPF_FMT_UID: last_index = `BAPF_UID_LAST;
      BAPF_FMT_TLM: last_index = `BAPF_TLM_LAST;
      BAPF_FMT_CUST: last_index = 5'(clen + 8'h03);
    endcase
  endfunction : last_index

  // pick byte k (0 = most significant) of a left-aligned field
  function automatic logic [7:0] msb_byte(input logic [191:0] v, input logic [4:0] k);
    logic [191:0] sh;
    sh = v << {k, 3'b000};
    msb_byte = sh[191:184];
  endfunction : msb_byte

  // payload byte at index i of layout f
  function automatic logic [7:0] frame_byte(input bapf_fmt_t f, input logic [4:0] i);
    logic [7:0] b;
    b = `BAPF_RSVD_BYTE;
    // (R1) common flags structure
    if (i == 5'd0) begin
      b = `BAPF_FLAGS_LEN;
    end else if (i == 5'd1) begin
      b = `BAPF_FLAGS_TYPE;
    end else if (i == 5'd2) begin
      // (R2) discoverable and no-classic bits
      b = `BAPF_FLAGS_VAL;
    end else begin
      unique case (f)
        // (R17) proprietary id, power last
        BAPF_FMT_PROP: begin
          if (i <= 5'd18) begin
            b = msb_byte({prop_id, 64'h0}, i - 5'd3);
          end else if (i <= 5'd20) begin
            b = msb_byte({prop_val_a, 176'h0}, i - 5'd19);
          end else if (i <= 5'd22) begin
            b = msb_byte({prop_val_b, 176'h0}, i - 5'd21);
          end else begin
            b = prop_tx_power;
          end
        end
        BAPF_FMT_UID, BAPF_FMT_TLM: begin
          // (R3) uuid list then service data header, uuid low byte first
          unique case (i)
            5'd3: b = `BAPF_UUID_LIST_LEN;
            5'd4: b = `BAPF_UUID_LIST_TYPE;
            5'd5: b = SVC_UUID[7:0];
            5'd6: b = SVC_UUID[15:8];
            // (R4) (R8) service-data length per frame
            5'd7: b = (f == BAPF_FMT_UID) ? `BAPF_UID_SD_LEN : `BAPF_TLM_SD_LEN;
            5'd8: b = `BAPF_SVC_DATA_TYPE;
            5'd9: b = SVC_UUID[7:0];
            5'd10: b = SVC_UUID[15:8];
            5'd11: b = (f == BAPF_FMT_UID) ? `BAPF_UID_FRAME : `BAPF_TLM_FRAME;
            // (R7) zero-metre power, else version
            5'd12: b = (f == BAPF_FMT_UID) ? uid_tx_power : `BAPF_TLM_VERSION;
            default: begin
              if (f == BAPF_FMT_UID) begin
                // (R5) namespace then instance; (R6) trailer zero
                if (i <= 5'd22) begin
                  b = msb_byte({uid_namespace, 112'h0}, i - 5'd13);
                end else if (i <= 5'd28) begin
                  b = msb_byte({uid_instance, 144'h0}, i - 5'd23);
                end else begin
                  b = `BAPF_RSVD_BYTE;
                end
              end else begin
                // (R9) (R10) (R11) (R12) (R13) big-endian telemetry
                if (i <= 5'd14) begin
                  b = msb_byte({battery_millivolts, 176'h0}, i - 5'd13);
                end else if (i <= 5'd16) begin
                  b = msb_byte({tlm_temperature, 176'h0}, i - 5'd15);
                end else if (i <= 5'd20) begin
                  b = msb_byte({adv_snap_ff, 160'h0}, i - 5'd17);
                end else begin
                  b = msb_byte({upt_snap_ff, 160'h0}, i - 5'd21);
                end
              end
            end
          endcase
        end
        BAPF_FMT_CUST: begin
          // (R14) (R15) (R16) manufacturer structure
          if (i == 5'd3) begin
            b = cust_len_cl;
          end else if (i == 5'd4) begin
            b = `BAPF_MFR_TYPE;
          end else if (i <= 5'd6) begin
            b = msb_byte({cust_company, 176'h0}, i - 5'd5);
          end else begin
            b = msb_byte(cust_data, i - 5'd7);
          end
        end
      endcase
    end
    frame_byte = b;
  endfunction : frame_byte

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BAPF_ST_IDLE: if (launch) nxt_state = BAPF_ST_SEND;
      BAPF_ST_SEND: if (done) nxt_state = BAPF_ST_IDLE;
      default: nxt_state = BAPF_ST_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= BAPF_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // layout selection written by software
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fmt_cfg_ff <= bapf_fmt_t'(`BAPF_CTRL_RST);
    end else if (reg_wr && (reg_addr == `BAPF_REG_CTRL)) begin
      fmt_cfg_ff <= bapf_fmt_t'(reg_wdata[`BAPF_CTRL_FMT_HI:`BAPF_CTRL_FMT_LO]);
    end
  end

  // layout, length and counter snapshot frozen for the whole payload
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fmt_ff <= BAPF_FMT_PROP;
      last_ff <= 5'h0;
      adv_snap_ff <= 32'h0;
      upt_snap_ff <= 32'h0;
    end else if (launch) begin
      fmt_ff <= fmt_cfg_ff;
      last_ff <= last_index(fmt_cfg_ff, cust_len_cl);
      adv_snap_ff <= adv_pdu_count;
      upt_snap_ff <= uptime_count;
    end
  end

  // (R18) index advances one per accepted byte before the last, from zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst || launch) begin
      idx_ff <= 5'h0;
    end else if (take && !tx_last) begin
      idx_ff <= idx_ff + 5'h1;
    end
  end

  // (R18) data register preloads the next byte on each acceptance
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_ff <= 8'h00;
    end else if (launch) begin
      data_ff <= frame_byte(fmt_cfg_ff, 5'h0);
    end else if (take && !tx_last) begin
      data_ff <= frame_byte(fmt_ff, idx_ff + 5'h1);
    end
  end

  assign tx_valid = (state_ff == BAPF_ST_SEND);
  assign tx_data = data_ff;
  // (R18) last byte flagged
  assign tx_last = tx_valid && (idx_ff == last_ff);

  // tally counts each payload handed over whole, except one whose last byte is taken in the cycle of a reboot
  bapf_tlm_cnt #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_cnt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reboot_clr(reboot_req),
    .pdu_done(done),
    .adv_pdu_count_ff(adv_pdu_count),
    .uptime_count_ff(uptime_count)
  );

  // read answer stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !reg_rd) begin
      rdata_ff <= 32'h0;
    end else begin
      unique case (reg_addr)
        `BAPF_REG_CTRL: rdata_ff <= {29'h0, fmt_cfg_ff, 1'b0};
        `BAPF_REG_STATUS: rdata_ff <= {19'h0, idx_ff, 7'h0, tx_valid};
        `BAPF_REG_ADVCNT: rdata_ff <= adv_pdu_count;
        `BAPF_REG_UPTIME: rdata_ff <= uptime_count;
        default: rdata_ff <= 32'h0;
      endcase
    end
  end
  assign reg_rdata = rdata_ff;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // (R1) flags opening
  a_flags_open: assert property (launch |=> tx_valid && tx_data == 8'h02 && idx_ff == 5'h0) // (R1)
    else $error("payload does not open with flags length");
  // (R2) flags value
  a_flags_value: assert property (tx_valid && idx_ff == 5'h2 |-> tx_data[1] && tx_data[2]) // (R2)
    else $error("flags value bits missing");
  // (R3) service data type
  a_svc_type: assert property (tx_valid && idx_ff == 5'h8 && fmt_ff != BAPF_FMT_PROP // (R3)
    && fmt_ff != BAPF_FMT_CUST |-> tx_data == 8'h16)
    else $error("service data type wrong");
  // (R4) uid frame header: service length and frame type
  a_uid_header: assert property (tx_valid && fmt_ff == BAPF_FMT_UID // (R4)
    && (idx_ff == 5'd7 || idx_ff == 5'd11) |-> tx_data == ((idx_ff == 5'd7) ? 8'h17 : 8'h00))
    else $error("uid service length or frame type wrong");
  // (R6) reserved trailer
  a_uid_trailer: assert property (tx_valid && fmt_ff == BAPF_FMT_UID && idx_ff >= 5'd29 // (R6)
    |-> tx_data == 8'h00)
    else $error("uid trailer not zero");
  // (R8) telemetry frame type
  a_tlm_type: assert property (tx_valid && fmt_ff == BAPF_FMT_TLM && idx_ff == 5'd11 // (R8)
    |-> tx_data == 8'h20)
    else $error("telemetry frame type wrong");
  // (R9) (R13) battery high byte first
  a_tlm_batt: assert property (tx_valid && fmt_ff == BAPF_FMT_TLM && idx_ff == 5'd13 // (R9)
    |-> tx_data == battery_millivolts[15:8])
    else $error("battery byte order wrong");
  // (R14) custom type and length bound
  a_cust_hdr: assert property (tx_valid && fmt_ff == BAPF_FMT_CUST // (R14)
    && (idx_ff == 5'd3 || idx_ff == 5'd4)
    |-> ((idx_ff == 5'd3) ? (tx_data <= 8'h1B) : (tx_data == 8'hFF)))
    else $error("custom header wrong");
  // (R18) index steps by one per handshake
  a_idx_step: assert property (take && !tx_last // (R18)
    |=> tx_valid && idx_ff == $past(idx_ff) + 5'h1)
    else $error("byte index did not step");
  // (R18) payload ends after last byte
  a_last_end: assert property (done |=> !tx_valid) // (R18)
    else $error("stream continued past last byte");
  // (R11) tally steps once per payload
  a_pdu_tally: assert property (done && !reboot_req // (R11)
    |=> adv_pdu_count == $past(adv_pdu_count) + 32'h1)
    else $error("pdu tally did not advance");

  c_uid_done: cover property (done && fmt_ff == BAPF_FMT_UID);
  c_tlm_done: cover property (done && fmt_ff == BAPF_FMT_TLM);
  c_cust_done: cover property (done && fmt_ff == BAPF_FMT_CUST);
  c_stall: cover property (tx_valid && !tx_ready ##1 take);

endmodule : bapf_framer

// [bapf_map.svh]
// bapf_map.svh : register offsets, field codes and timing counts for the beacon framer
`ifndef BAPF_MAP_SVH
`define BAPF_MAP_SVH

// register byte offsets
`define BAPF_REG_CTRL 8'h00
`define BAPF_REG_STATUS 8'h04
`define BAPF_REG_ADVCNT 8'h08
`define BAPF_REG_UPTIME 8'h0C

// control register fields
`define BAPF_CTRL_START 0
`define BAPF_CTRL_FMT_LO 1
`define BAPF_CTRL_FMT_HI 2
`define BAPF_CTRL_REBOOT 3
`define BAPF_CTRL_RST 2'h0

// status register fields
`define BAPF_STAT_BUSY 0
`define BAPF_STAT_IDX_LO 8
`define BAPF_STAT_IDX_HI 12

// flags structure
`define BAPF_FLAGS_LEN 8'h02
`define BAPF_FLAGS_TYPE 8'h01
`define BAPF_FLAGS_VAL 8'h06
`define BAPF_FLAG_GEN_DISC 1
`define BAPF_FLAG_NO_BREDR 2

// structure types and lengths
`define BAPF_UUID_LIST_LEN 8'h03
`define BAPF_UUID_LIST_TYPE 8'h03
`define BAPF_SVC_DATA_TYPE 8'h16
`define BAPF_UID_SD_LEN 8'h17
`define BAPF_UID_FRAME 8'h00
`define BAPF_TLM_SD_LEN 8'h10
`define BAPF_TLM_FRAME 8'h20
`define BAPF_TLM_VERSION 8'h00
`define BAPF_RSVD_BYTE 8'h00
`define BAPF_MFR_TYPE 8'hFF
`define BAPF_MFR_LEN_MAX 8'h1B
`define BAPF_MFR_LEN_MIN 8'h03

// last byte index of each fixed-length layout
`define BAPF_PROP_LAST 5'h17
`define BAPF_UID_LAST 5'h1E
`define BAPF_TLM_LAST 5'h18

// timing: clock period and uptime tick
`define BAPF_CLK_PERIOD_NS 4
`define BAPF_UPTIME_TICK_MS 1000
`define BAPF_UPTIME_TICK_CYC ((`BAPF_UPTIME_TICK_MS * 1000000) / `BAPF_CLK_PERIOD_NS)

`endif

// [bapf_pkg.sv]
// bapf_pkg.sv : types shared by the beacon payload framer files
package bapf_pkg;

  // payload layout selection
  typedef enum logic [1:0] {
    BAPF_FMT_PROP = 2'h0,
    BAPF_FMT_UID = 2'h1,
    BAPF_FMT_TLM = 2'h2,
    BAPF_FMT_CUST = 2'h3
  } bapf_fmt_t;

  // framer sequencer states, one-hot
  typedef enum logic [1:0] {
    BAPF_ST_IDLE = 2'b01,
    BAPF_ST_SEND = 2'b10
  } bapf_state_t;

endpackage : bapf_pkg

// [bapf_tlm_cnt.sv]
// bapf_tlm_cnt.sv : advertising pdu tally and uptime counter for the telemetry frame
`timescale 1ns/1ps
`include "bapf_map.svh"
module bapf_tlm_cnt #(
  parameter int TICK_CYCLES = `BAPF_UPTIME_TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // events
  input wire logic reboot_clr,
  input wire logic pdu_done,
  // counts
  output logic [31:0] adv_pdu_count_ff,
  output logic [31:0] uptime_count_ff
);

  // refuse a tick period the prescaler cannot count
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("bapf_tlm_cnt: TICK_CYCLES must be at least 1");
  end

  logic [31:0] presc_ff; // cycles within the current uptime tick
  logic tick; // one uptime unit elapsed

  assign tick = (presc_ff == 32'(TICK_CYCLES - 1));

  // prescaler restarts on reboot so the first tick is a full period
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reboot_clr || tick) begin
      presc_ff <= 32'h0;
    end else begin
      presc_ff <= presc_ff + 32'h1;
    end
  end

  // (R11) pdu tally, cleared by reset or reboot
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reboot_clr) begin
      adv_pdu_count_ff <= 32'h0;
    end else if (pdu_done) begin
      adv_pdu_count_ff <= adv_pdu_count_ff + 32'h1;
    end
  end

  // (R12) uptime, cleared by reset or reboot
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reboot_clr) begin
      uptime_count_ff <= 32'h0;
    end else if (tick) begin
      uptime_count_ff <= uptime_count_ff + 32'h1;
    end
  end

endmodule : bapf_tlm_cnt

// [bapf_radio_model.sv]
// bapf_radio_model.sv : radio transmitter model that takes the framer byte stream
`timescale 1ns/1ps
module bapf_radio_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // stall control from the bench
  input wire logic slow,
  // byte stream from the framer
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  // captured traffic for the bench
  output logic [7:0] cap_ff [0:255],
  output logic [7:0] cap_cnt_ff,
  output int frame_cnt_ff
);
  // ready pattern: slow mode drops ready every other cycle so stalls hit every byte slot that follows an accepted byte
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cap_cnt_ff <= 8'h00;
      frame_cnt_ff <= 0;
    end else if (tx_valid && tx_ready) begin
      // store wraps around; the bench keeps runs under 256 bytes between checks
      cap_ff[cap_cnt_ff] <= tx_data;
      cap_cnt_ff <= cap_cnt_ff + 8'h01;
      // a last byte closes the payload
      if (tx_last) begin
        frame_cnt_ff <= frame_cnt_ff + 1;
      end
    end
  end
endmodule : bapf_radio_model

// [beacon_adv_payload_framer_test.sv]
// beacon_adv_payload_framer_test.sv : self-checking bench for the beacon payload framer
`timescale 1ns/1ps
`include "bapf_map.svh"
module beacon_adv_payload_framer_test;
  import bapf_pkg::*;
  localparam logic [15:0] UUID = 16'h3C81; // arbitrary value
  localparam int TICK = 200; // short uptime tick keeps the run brief
  // clock, reset and register port
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // payload fields stay steady through each payload
  logic [127:0] prop_id = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  logic [15:0] prop_val_a = 16'hA1B2;
  logic [15:0] prop_val_b = 16'hC3D4;
  logic [7:0] prop_tx_power = 8'hC5;
  logic [7:0] uid_tx_power = 8'hEE;
  logic [79:0] uid_namespace = 80'h112233445566778899AA;
  logic [47:0] uid_instance = 48'hBBCCDDEEFF01;
  logic [15:0] battery_millivolts = 16'h0BB8;
  logic [15:0] tlm_temperature = 16'h1980;
  logic [7:0] cust_len = 8'h1B;
  logic [15:0] cust_company = 16'h4D2F;
  logic [191:0] cust_data = 192'h0102030405060708090A0B0C0D0E0F101112131415161718;
  // stream and model taps
  logic tx_valid;
  logic tx_ready;
  logic tx_last;
  logic [7:0] tx_data;
  logic slow = 1'b0;
  logic [7:0] cap [0:255];
  logic [7:0] cap_cnt;
  int frame_cnt;
  // expected payload and tallies
  logic [7:0] exp_b [0:31];
  int exp_n;
  int error_cnt = 0;
  int check_count = 0;

  // clock at 250 MHz
  always #2 clk_sys = ~clk_sys;

  bapf_framer #(.SVC_UUID(UUID), .TICK_CYCLES(TICK)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .prop_id(prop_id), .prop_val_a(prop_val_a), .prop_val_b(prop_val_b),
    .prop_tx_power(prop_tx_power), .uid_tx_power(uid_tx_power),
    .uid_namespace(uid_namespace), .uid_instance(uid_instance),
    .battery_millivolts(battery_millivolts), .tlm_temperature(tlm_temperature),
    .cust_len(cust_len), .cust_company(cust_company), .cust_data(cust_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last)
  );

  bapf_radio_model MODEL (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .cap_ff(cap), .cap_cnt_ff(cap_cnt), .frame_cnt_ff(frame_cnt)
  );

  // one comparison, counted, mismatch printed at once
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // single-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // flags structure common to every layout
  task automatic hdr();
    exp_b[0] = 8'h02;
    exp_b[1] = 8'h01;
    exp_b[2] = 8'h06;
  endtask : hdr

  // uuid list and service-data header shared by unique-id and telemetry
  task automatic svc(input logic [7:0] len, input logic [7:0] ftype, input logic [7:0] b12);
    exp_b[3] = 8'h03;
    exp_b[4] = 8'h03;
    exp_b[5] = UUID[7:0];
    exp_b[6] = UUID[15:8];
    exp_b[7] = len;
    exp_b[8] = 8'h16;
    exp_b[9] = UUID[7:0];
    exp_b[10] = UUID[15:8];
    exp_b[11] = ftype;
    exp_b[12] = b12;
  endtask : svc

  // select layout, start, optionally poke a start while busy, then compare the bytes
  task automatic run_frame(input bapf_fmt_t fmt, input logic poke);
    logic [7:0] base;
    logic [31:0] rd;
    int f0;
    int n;
    base = cap_cnt;
    f0 = frame_cnt;
    reg_write(`BAPF_REG_CTRL, {29'h0, fmt, 1'b0});
    reg_write(`BAPF_REG_CTRL, {29'h0, fmt, 1'b1});
    if (poke) begin
      reg_write(`BAPF_REG_CTRL, {29'h0, fmt, 1'b1});
      reg_read(`BAPF_REG_STATUS, rd);
      cmp({31'h0, rd[0]}, 32'h1);
    end
    n = 0;
    while (frame_cnt == f0 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    // a payload that never ends counts as a mismatch
    cmp(32'(frame_cnt - f0), 32'h1);
    repeat (3) @(posedge clk_sys);
    #1;
    cmp({31'h0, tx_valid}, 32'h0);
    cmp(32'(8'(cap_cnt - base)), 32'(exp_n));
    for (int i = 0; i < exp_n; i++) begin
      cmp(32'(cap[8'(base + i)]), 32'(exp_b[i]));
    end
  endtask : run_frame

  // reset values, an unmapped read and an unmapped write
  task automatic test_reset();
    logic [31:0] rd;
    for (int i = 0; i < 5; i++) begin
      reg_read(8'(i * 4), rd);
      cmp(rd, 32'h0);
    end
    reg_write(8'h10, 32'h00000001);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp({31'h0, tx_valid}, 32'h0);
  endtask : test_reset

  // unique-id frame under a stalling radio, with a start refused mid-payload
  task automatic test_uid();
    logic [31:0] rd;
    hdr();
    svc(8'h17, 8'h00, uid_tx_power);
    for (int i = 0; i < 10; i++) begin
      exp_b[13 + i] = uid_namespace[79 - 8 * i -: 8];
    end
    for (int i = 0; i < 6; i++) begin
      exp_b[23 + i] = uid_instance[47 - 8 * i -: 8];
    end
    exp_b[29] = 8'h00;
    exp_b[30] = 8'h00;
    exp_n = 31;
    slow <= 1'b1;
    run_frame(BAPF_FMT_UID, 1'b1);
    slow <= 1'b0;
    // layout field reads back in bits 2:1
    reg_read(`BAPF_REG_CTRL, rd);
    cmp(rd, 32'h2);
  endtask : test_uid

  // proprietary id layout
  task automatic test_prop();
    hdr();
    for (int i = 0; i < 16; i++) begin
      exp_b[3 + i] = prop_id[127 - 8 * i -: 8];
    end
    exp_b[19] = prop_val_a[15:8];
    exp_b[20] = prop_val_a[7:0];
    exp_b[21] = prop_val_b[15:8];
    exp_b[22] = prop_val_b[7:0];
    exp_b[23] = prop_tx_power;
    exp_n = 24;
    run_frame(BAPF_FMT_PROP, 1'b0);
  endtask : test_prop

  // telemetry twice after a reboot, then tallies, uptime and a second reboot
  task automatic test_tlm();
    logic [31:0] rd;
    reg_write(`BAPF_REG_CTRL, 32'h0000000C);
    for (int k = 0; k < 2; k++) begin
      hdr();
      svc(8'h10, 8'h20, 8'h00);
      exp_b[13] = battery_millivolts[15:8];
      exp_b[14] = battery_millivolts[7:0];
      exp_b[15] = tlm_temperature[15:8];
      exp_b[16] = tlm_temperature[7:0];
      for (int i = 0; i < 8; i++) begin
        exp_b[17 + i] = 8'h00;
      end
      exp_b[20] = 8'(k);
      exp_n = 25;
      run_frame(BAPF_FMT_TLM, 1'b0);
    end
    // both payloads ended well inside the first tick, so three ticks have now passed
    repeat (3 * TICK) @(posedge clk_sys);
    reg_read(`BAPF_REG_UPTIME, rd);
    cmp(rd, 32'h3);
    reg_read(`BAPF_REG_ADVCNT, rd);
    cmp(rd, 32'h2);
    reg_write(`BAPF_REG_CTRL, 32'h00000008);
    reg_read(`BAPF_REG_ADVCNT, rd);
    cmp(rd, 32'h0);
    reg_read(`BAPF_REG_UPTIME, rd);
    cmp(rd, 32'h0);
  endtask : test_tlm

  // custom frames at too-short, small, maximum and over-long lengths
  task automatic test_cust();
    logic [7:0] lens [0:3];
    logic [7:0] len;
    lens = '{8'h01, 8'h05, 8'h1B, 8'h20};
    for (int j = 0; j < 4; j++) begin
      // announced length is held to 3..0x1B
      len = (lens[j] > 8'h1B) ? 8'h1B : ((lens[j] < 8'h03) ? 8'h03 : lens[j]);
      @(posedge clk_sys);
      cust_len <= lens[j];
      slow <= 1'(j % 2);
      hdr();
      exp_b[3] = len;
      exp_b[4] = 8'hFF;
      exp_b[5] = cust_company[15:8];
      exp_b[6] = cust_company[7:0];
      for (int i = 0; i < 24; i++) begin
        exp_b[7 + i] = cust_data[191 - 8 * i -: 8];
      end
      exp_n = 32'(len) + 4;
      run_frame(BAPF_FMT_CUST, 1'b0);
    end
  endtask : test_cust

  // verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // main sequence: reset for 8 cycles, then each scenario
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_reset();
    test_uid();
    test_prop();
    test_tlm();
    test_cust();
    end_of_test();
  end

  // watchdog: the run needs about 1000 cycles, so 20000 cycles means a hang
  initial begin
    #80000;
    error_cnt++;
    end_of_test();
  end
endmodule : beacon_adv_payload_framer_test
